// ===== include/cfg_seq_defines.svh
// Timing counts and pin levels of the configuration lifephase sequencer
`ifndef CFG_SEQ_DEFINES_SVH
`define CFG_SEQ_DEFINES_SVH
`define CLK_FREQ_HZ 20000000
`define CLEAR_CYCLE_MSEC 2
`define CLEAR_CYCLE_CYC ((`CLEAR_CYCLE_MSEC * `CLK_FREQ_HZ) / 1000)
`define INIT_LOW_US 1
`define INIT_LOW_CYC ((`INIT_LOW_US * `CLK_FREQ_HZ) / 1000000)
`define START_LOW_PERIODS 3
`define MODE_AUTO 3'h0
`define CNT_W 20
`define FIFO_W 8
`define FIFO_D 16
`endif

// ===== include/cfg_seq_pkg.sv
// Types shared by the configuration lifephase sequencer
package cfg_seq_pkg;
  typedef enum logic [2:0] {
    PH_POWER_ON,
    PH_MANUAL,
    PH_INIT_LOW,
    PH_MODE_SAMPLE,
    PH_IDLE,
    PH_START_WAIT,
    PH_DOWNLOAD,
    PH_AUTO
  } phase_t;
endpackage

// ===== include/cfg_stream_if.sv
// Stream carrier between the bit packer and the data FIFO
`timescale 1ns/100ps
interface cfg_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== src/cfg_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cfg_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ===== src/cfg_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module cfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  cfg_stream_if.snk wr,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic full, empty, do_wr, do_rd;

  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign wr.ready = !full;
  assign rd_valid = !empty;
  assign do_wr = wr.valid && !full;
  assign do_rd = rd_ready && !empty;
  assign rd_data = mem_q[rp_q[AW-1:0]];

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
    end else begin
      if (do_wr) wp_d = wp_q + 1'b1;
      if (do_rd) rp_d = rp_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Storage needs no reset; pointers guard it
  always_ff @(posedge clk) begin
    if (do_wr && !flush) mem_q[wp_q[AW-1:0]] <= wr.data;
  end
endmodule

// ===== src/cfg_lifephase.sv
// Configuration lifephase sequencer for slave serial mode
`timescale 1ns/100ps
`include "cfg_seq_defines.svh"

// Summary of operation
// - Power-on reset phase ends when the clear cycle count ends.
// - Power-on: init released until clear end, then low about 1 us.
// - Start/done pin driven low in reset and mode sampling phases.
// - Low-during-config low, high-during-config high in those phases.
// - Manual reset input ignored during power-on reset.
// - Mode select pins unused during reset phases.
// - Mode sampling reads mode pins; mode 0 starts auto download.
// - Serial data shows first EEPROM bit during mode sampling.
// - Manual reset in mode sampling or idle returns to manual reset.
// - Idle entered when start/done and init released; start/done high.
// - In idle the config pins become general purpose with pull-ups.
// - After reset in modes other than 0 the unit stays unconfigured in idle awaiting download.
// - Activating manual reset input enters manual reset phase.
// - Manual reset starts clear cycle at once, lasting about 2 ms.
// - Short manual reset pulse still holds phase until clear end.
// - Init pin driven low in manual reset until input released.
// - No config clock generated; clock, select, data only pulled up.
// - Start/done low three clock periods makes device drive it low.
module cfg_lifephase
  import cfg_seq_pkg::*;
#(
  parameter int CLEAR_CYC = `CLEAR_CYCLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic manual_reset_n,
  input wire logic mode_select_bit0,
  input wire logic mode_select_bit1,
  input wire logic mode_select_bit2,
  input wire logic config_clock,
  input wire logic serial_config_data,
  input wire logic config_chip_select,
  input wire logic start_done_in,
  output logic start_done_out,
  output logic start_done_oe_n,
  input wire logic init_error_in,
  output logic init_error_out,
  output logic init_error_oe_n,
  output logic low_during_config_out,
  output logic high_during_config_out,
  output logic config_pins_gpio,
  output logic clear_cycle_end,
  output logic mode_sampling_phase,
  output logic auto_download_req,
  output logic [2:0] sampled_mode,
  output logic [2:0] phase,
  output logic cfg_valid,
  input wire logic cfg_ready,
  output logic [7:0] cfg_data
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [6:0] raw_in, sync_in;
  logic mrst_n_s, sck_s, sdi_s, cs_s, sd_s, init_s;
  logic [2:0] mode_s;
  assign raw_in = {manual_reset_n, config_clock, serial_config_data,
                   config_chip_select, start_done_in, init_error_in,
                   mode_select_bit0};
  cfg_sync #(.W(7)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(raw_in),
    .sync_out(sync_in)
  );
  cfg_sync #(.W(2)) u_sync_m (
    .clk(clk),
    .resetn(resetn),
    .async_in({mode_select_bit2, mode_select_bit1}),
    .sync_out(mode_s[2:1])
  );
  assign {mrst_n_s, sck_s, sdi_s, cs_s, sd_s, init_s, mode_s[0]} = sync_in;

  // ****************************************
  // Lifephase state machine
  // ****************************************
  phase_t st_q, st_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic sck_prev_q, sck_prev_d, init_prev_q, init_prev_d;
  logic [1:0] low_cnt_q, low_cnt_d;
  logic [2:0] mode_q, mode_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] shift_q, shift_d;
  logic sd_drive_q, sd_drive_d;
  logic sck_rise, clear_done, init_rise, flush;
  cfg_stream_if s_if ();

  assign sck_rise = sck_s && !sck_prev_q;
  assign init_rise = init_s && !init_prev_q;
  assign clear_done = (cnt_q == `CNT_W'(CLEAR_CYC - 1));

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sck_prev_d = sck_s;
    init_prev_d = init_s;
    low_cnt_d = low_cnt_q;
    mode_d = mode_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    sd_drive_d = sd_drive_q;
    case (st_q)
      // Manual reset input not looked at here
      PH_POWER_ON: begin
        cnt_d = cnt_q + 1'b1;
        if (clear_done) begin
          st_d = PH_INIT_LOW;
          cnt_d = '0;
        end
      end
      PH_MANUAL: begin
        if (!clear_done) cnt_d = cnt_q + 1'b1;
        if (clear_done && mrst_n_s) begin
          st_d = PH_INIT_LOW;
          cnt_d = '0;
        end
      end
      PH_INIT_LOW: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == `CNT_W'(`INIT_LOW_CYC - 1)) begin
          st_d = PH_MODE_SAMPLE;
          cnt_d = '0;
        end
      end
      PH_MODE_SAMPLE: begin
        // Wait for the released init pin to read high before sampling
        if (init_rise || init_s) begin
          mode_d = mode_s;
          if (mode_s == `MODE_AUTO) st_d = PH_AUTO;
          else st_d = PH_IDLE;
        end
      end
      PH_IDLE: begin
        low_cnt_d = '0;
        if (!sd_s && !cs_s) st_d = PH_START_WAIT;
      end
      PH_START_WAIT: begin
        if (sd_s) st_d = PH_IDLE;
        else if (sck_rise) begin
          low_cnt_d = low_cnt_q + 1'b1;
          if (low_cnt_q == 2'(`START_LOW_PERIODS - 1)) begin
            st_d = PH_DOWNLOAD;
            sd_drive_d = 1'b1;
            bit_cnt_d = '0;
          end
        end
      end
      PH_DOWNLOAD: begin
        // Download ends when the master lifts chip select
        if (cs_s) begin
          st_d = PH_IDLE;
          sd_drive_d = 1'b0;
        end else if (sck_rise && s_if.ready) begin
          shift_d = {shift_q[6:0], sdi_s};
          bit_cnt_d = bit_cnt_q + 1'b1;
        end
      end
      PH_AUTO: ;
      default: st_d = PH_POWER_ON;
    endcase
    if (!mrst_n_s && st_q != PH_POWER_ON && st_q != PH_MANUAL) begin
      st_d = PH_MANUAL;
      cnt_d = '0;
      sd_drive_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= PH_POWER_ON;
      cnt_q <= '0;
      sck_prev_q <= 1'b1;
      init_prev_q <= 1'b1;
      low_cnt_q <= '0;
      mode_q <= '0;
      bit_cnt_q <= '0;
      shift_q <= '0;
      sd_drive_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sck_prev_q <= sck_prev_d;
      init_prev_q <= init_prev_d;
      low_cnt_q <= low_cnt_d;
      mode_q <= mode_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      sd_drive_q <= sd_drive_d;
    end
  end

  // ****************************************
  // Byte stream into the FIFO
  // ****************************************
  logic byte_pend_q, byte_pend_d;
  always_comb begin
    byte_pend_d = byte_pend_q;
    if (st_q == PH_DOWNLOAD && sck_rise && s_if.ready && bit_cnt_q == 3'h7)
      byte_pend_d = 1'b1;
    else if (s_if.ready)
      byte_pend_d = 1'b0;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) byte_pend_q <= 1'b0;
    else byte_pend_q <= byte_pend_d;
  end
  assign s_if.valid = byte_pend_q;
  assign s_if.data = shift_q;
  assign flush = (st_q == PH_MANUAL);

  cfg_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_D)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(flush),
    .wr(s_if),
    .rd_valid(cfg_valid),
    .rd_ready(cfg_ready),
    .rd_data(cfg_data)
  );

  // ****************************************
  // Pin drive
  // ****************************************
  logic in_reset;
  assign in_reset = (st_q == PH_POWER_ON) || (st_q == PH_MANUAL) ||
                    (st_q == PH_INIT_LOW) || (st_q == PH_MODE_SAMPLE);
  assign start_done_out = 1'b0;
  assign start_done_oe_n = !(in_reset || sd_drive_q);
  assign init_error_out = 1'b0;
  assign init_error_oe_n = !((st_q == PH_INIT_LOW) ||
                             (st_q == PH_MANUAL && !mrst_n_s));
  assign low_during_config_out = !(in_reset || sd_drive_q);
  assign high_during_config_out = in_reset || sd_drive_q;
  // Clock, select and data are never driven here; pads hold pull-ups
  assign config_pins_gpio = !in_reset && !sd_drive_q;
  assign clear_cycle_end = (st_q == PH_INIT_LOW);
  assign mode_sampling_phase = (st_q == PH_MODE_SAMPLE);
  assign auto_download_req = (st_q == PH_AUTO);
  assign sampled_mode = mode_q;
  assign phase = st_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // States listed here rather than in_reset, so a slip there is caught
  AST_START_LOW: assert property (
    st_q inside {PH_POWER_ON, PH_MANUAL, PH_INIT_LOW, PH_MODE_SAMPLE}
    |-> !start_done_oe_n)
    else $error("start/done not driven low in reset");
  AST_LDC_HDC: assert property (
    st_q inside {PH_POWER_ON, PH_MANUAL, PH_INIT_LOW, PH_MODE_SAMPLE}
    |-> !low_during_config_out && high_during_config_out)
    else $error("ldc/hdc wrong in reset");
  AST_POR_NO_MRST: assert property (
    st_q == PH_POWER_ON && !clear_done |=> st_q == PH_POWER_ON)
    else $error("power-on left early");
  AST_INIT_PULSE: assert property (
    $rose(st_q == PH_INIT_LOW) |-> (!init_error_oe_n)[*8])
    else $error("init low pulse too short");
  AST_MRST_RET: assert property (
    !mrst_n_s && (st_q == PH_IDLE || st_q == PH_MODE_SAMPLE)
    |=> st_q == PH_MANUAL)
    else $error("manual reset not honoured");
  AST_MAN_HOLD: assert property (
    st_q == PH_MANUAL && !clear_done |=> st_q == PH_MANUAL)
    else $error("manual reset left before clear end");
  AST_INIT_MAN: assert property (
    st_q == PH_MANUAL && !mrst_n_s |-> !init_error_oe_n)
    else $error("init not low in manual reset");
  AST_IDLE_REL: assert property (
    st_q == PH_IDLE
    |-> start_done_oe_n && init_error_oe_n && config_pins_gpio)
    else $error("idle pins not released");
  AST_MODE0: assert property (
    st_q == PH_MODE_SAMPLE && init_s && mrst_n_s && mode_s == 3'h0
    |=> st_q == PH_AUTO)
    else $error("mode 0 did not start auto download");
  AST_DL_DRIVE: assert property (
    st_q == PH_DOWNLOAD |-> !start_done_oe_n)
    else $error("start/done not held during download");
  COV_IDLE: cover property (st_q == PH_MODE_SAMPLE ##1 st_q == PH_IDLE);
  COV_MAN: cover property (st_q == PH_IDLE ##1 st_q == PH_MANUAL);
  COV_DL: cover property (st_q == PH_START_WAIT ##1 st_q == PH_DOWNLOAD);
endmodule

// ===== tb/cfg_far_side.sv
// Far-side model: serial memory plus the download start component
`timescale 1ns/100ps
module cfg_far_side (
  input wire logic start_done_oe_n,
  output logic config_clock,
  output logic serial_config_data,
  output logic config_chip_select,
  output logic start_pull_low
);
  // Lines rest at their pull-up level and the clock stands still
  initial begin
    config_clock = 1'b1;
    serial_config_data = 1'b1;
    config_chip_select = 1'b1;
    start_pull_low = 1'b0;
  end

  // One bit per rising edge, data set up half a period before
  task automatic tick(input logic b);
    config_clock = 1'b0;
    serial_config_data = b;
    #200;
    config_clock = 1'b1;
    #200;
  endtask

  task automatic start_dl();
    int n;
    n = 0;
    #37;
    config_chip_select = 1'b0;
    start_pull_low = 1'b1;
    repeat (3) tick(1'b1);
    // Let go only once the device holds the pin itself
    while (start_done_oe_n !== 1'b0 && n < 100) begin
      #50;
      n++;
    end
    start_pull_low = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tick(b[i]);
    end
    serial_config_data = 1'b1;
  endtask

  task automatic end_dl();
    config_chip_select = 1'b1;
  endtask
endmodule

// ===== tb/slave_serial_config_reset_sequencer_tb.sv
// Self-checking bench of the configuration lifephase sequencer
`timescale 1ns/100ps
`include "cfg_seq_defines.svh"
module slave_serial_config_reset_sequencer_tb
  import cfg_seq_pkg::*;
;
  localparam int C = 50;
  logic clk, resetn, manual_reset_n, cfg_ready;
  logic [2:0] mode_sel;
  logic config_clock, serial_config_data, config_chip_select;
  logic start_pull_low, start_done_in, start_done_out, start_done_oe_n;
  logic init_error_in, init_error_out, init_error_oe_n;
  logic ldc, hdc, gpio, cce, msp, auto_req, cfg_valid;
  logic [2:0] sampled_mode, phase;
  logic [7:0] cfg_data;
  int n_mismatch = 0;
  int tests_run = 0;

  // Wired levels: device drive wins, else the far side, else pull-up
  assign start_done_in = !start_done_oe_n ? start_done_out : !start_pull_low;
  assign init_error_in = !init_error_oe_n ? init_error_out : 1'b1;

  cfg_lifephase #(.CLEAR_CYC(C)) u_cfg_lifephase (
    .clk(clk), .resetn(resetn), .manual_reset_n(manual_reset_n),
    .mode_select_bit0(mode_sel[0]), .mode_select_bit1(mode_sel[1]),
    .mode_select_bit2(mode_sel[2]), .config_clock(config_clock),
    .serial_config_data(serial_config_data),
    .config_chip_select(config_chip_select),
    .start_done_in(start_done_in), .start_done_out(start_done_out),
    .start_done_oe_n(start_done_oe_n), .init_error_in(init_error_in),
    .init_error_out(init_error_out), .init_error_oe_n(init_error_oe_n),
    .low_during_config_out(ldc), .high_during_config_out(hdc),
    .config_pins_gpio(gpio), .clear_cycle_end(cce),
    .mode_sampling_phase(msp), .auto_download_req(auto_req),
    .sampled_mode(sampled_mode), .phase(phase), .cfg_valid(cfg_valid),
    .cfg_ready(cfg_ready), .cfg_data(cfg_data));

  cfg_far_side u_cfg_far_side (
    .start_done_oe_n(start_done_oe_n), .config_clock(config_clock),
    .serial_config_data(serial_config_data),
    .config_chip_select(config_chip_select),
    .start_pull_low(start_pull_low));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_phase(input logic [2:0] p, input int lim,
                            output int n);
    n = 0;
    while (phase !== p && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic check_released(input logic [2:0] m);
    check(phase, PH_IDLE, "idle phase");
    check(start_done_oe_n, 1'b1, "start/done released");
    check(init_error_oe_n, 1'b1, "init released");
    check({ldc, hdc, gpio}, 3'h5, "pins back to general use");
    check(sampled_mode, m, "sampled mode");
    check(auto_req, 1'b0, "no auto download");
    check(msp, 1'b0, "mode sampling over");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_on();
    int n, w;
    @(posedge clk);
    resetn <= 1'b1;
    manual_reset_n <= 1'b0;
    mode_sel <= 3'h6;
    repeat (10) @(negedge clk);
    check(phase, PH_POWER_ON, "manual reset ignored");
    check(start_done_oe_n, 1'b0, "start/done driven");
    check({ldc, hdc}, 2'h1, "config level outputs");
    check(init_error_oe_n, 1'b1, "init pulled up");
    @(posedge clk);
    manual_reset_n <= 1'b1;
    mode_sel <= 3'h1;
    wait_phase(PH_INIT_LOW, 2 * C, n);
    check(init_error_oe_n, 1'b0, "init low at clear end");
    check(n + 11 >= C, 1'b1, "clear cycle length");
    check(cce, 1'b1, "clear cycle end flag");
    w = 0;
    while (init_error_oe_n === 1'b0 && w < 100) begin
      @(negedge clk);
      w++;
    end
    check(w, `INIT_LOW_CYC, "init low width");
    check(phase, PH_MODE_SAMPLE, "mode sampling entered");
    check(msp, 1'b1, "mode sampling flag");
    wait_phase(PH_IDLE, 20, n);
    check_released(3'h1);
    $display("test power_on done");
  endtask

  task automatic t_manual(input int hold, input logic [2:0] m,
                          input logic [2:0] endp);
    int n, k;
    logic ok;
    ok = 1'b1;
    @(posedge clk);
    mode_sel <= m;
    manual_reset_n <= 1'b0;
    wait_phase(PH_MANUAL, 10, n);
    check(n <= 4, 1'b1, "manual reset entered");
    check(start_done_oe_n, 1'b0, "start/done driven");
    check({ldc, hdc}, 2'h1, "config level outputs");
    for (k = n; k < hold; k++) begin
      @(negedge clk);
      ok &= (init_error_oe_n === 1'b0) && (phase === PH_MANUAL);
    end
    check(ok, 1'b1, "init low while input held");
    @(posedge clk);
    manual_reset_n <= 1'b1;
    n = 0;
    while (phase === PH_MANUAL && n < 3 * C) begin
      @(negedge clk);
      n++;
    end
    check(hold + n + 4 >= C, 1'b1, "clear cycle kept");
    wait_phase(endp, 200, n);
    if (endp === PH_AUTO) begin
      check(auto_req, 1'b1, "auto download on mode 0");
      check(sampled_mode, m, "sampled mode");
    end
    else check_released(m);
    $display("test manual hold %0d mode %0d done", hold, m);
  endtask

  task automatic t_download();
    int n, i;
    @(posedge clk);
    cfg_ready <= 1'b0;
    u_cfg_far_side.start_dl();
    check(start_done_oe_n, 1'b0, "device holds start/done");
    // Two bytes beyond the depth are sent into a full buffer
    for (i = 0; i < 18; i++) u_cfg_far_side.send_byte(8'h3c + 8'(i * 7));
    repeat (8) @(negedge clk);
    check(cfg_valid, 1'b1, "buffer holds data");
    @(posedge clk);
    cfg_ready <= 1'b1;
    i = 0;
    n = 0;
    while (i < 16 && n < 100) begin
      @(negedge clk);
      n++;
      if (cfg_valid === 1'b1) begin
        check(cfg_data, 8'h3c + 8'(i * 7), "byte order");
        i++;
      end
    end
    @(negedge clk);
    check(cfg_valid, 1'b0, "full buffer dropped extras");
    check(i, 16, "bytes drained");
    @(posedge clk);
    cfg_ready <= 1'b0;
    @(negedge clk);
    u_cfg_far_side.end_dl();
    wait_phase(PH_IDLE, 20, n);
    check(start_done_oe_n, 1'b1, "start/done released");
    $display("test download done");
  endtask

  initial begin
    resetn = 1'b0;
    manual_reset_n = 1'b1;
    cfg_ready = 1'b0;
    mode_sel = 3'h1;
    repeat (20) @(posedge clk);
    t_power_on();
    t_manual(5, 3'h1, PH_IDLE);
    t_manual(2 * C, 3'h1, PH_IDLE);
    t_manual(5, 3'h0, PH_AUTO);
    t_manual(5, 3'h1, PH_IDLE);
    t_download();
    close_out();
  end

  // Whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule
